//--- inc/cal_seq_defines.vh
// Purpose: shared constants of the calibration sequencer
// Assumes: included by its bare name from every design file except the cycle timer
// Notes: offsets are byte addresses on the register bus
`ifndef CAL_SEQ_DEFINES_VH
`define CAL_SEQ_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_INT_STATUS 8'h08
`define REG_INT_MASK 8'h0C
`define REG_TRIM_LEN 8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_EXT_MODE 0
`define CTRL_DES_MODE 1
`define CTRL_W 2
`define STAT_IN_PROGRESS 0
`define STAT_POWERED_DOWN 1
`define STAT_OVERFLOW 2
`define STAT_SETTLED 3
`define STAT_ANALOG_PD 4
`define STAT_W 5
`define IRQ_TRIM_START 0
`define IRQ_TRIM_DONE 1
`define IRQ_OVERFLOW 2
`define IRQ_REQ_IGNORED 3
`define IRQ_W 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTRL_RESET 2'h0
`define INT_MASK_RESET 4'h0
`define TRIM_LEN_RESET 16'h0400

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define QUAL_CYCLES 80
`define CLK_PERIOD_NS 25
`define SETTLE_NS 100
`define SETTLE_CYCLES ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DLY_SHORT_CYCLES 24'h000400
`define DLY_LONG_CYCLES 24'h010000

`endif

//--- rtl/request_qualifier.v
// Purpose: synchronise the trim request pin and qualify low/high intervals
// Assumes: req_pin is asynchronous to aclk
// Notes: trigger is a one-cycle pulse on the last qualifying high cycle
`timescale 1ns/100ps
`default_nettype none
`include "cal_seq_defines.vh"

module request_qualifier #(
  parameter QUAL = `QUAL_CYCLES
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // pin side
  input wire req_pin,
  // results
  output wire req_level,
  output reg trigger
);

  reg req_meta;
  reg req_sync;
  reg [7:0] low_cnt;
  reg [7:0] high_cnt;
  reg armed;

  assign req_level = req_sync;

  // two flops before anything looks at the pin
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      req_meta <= 1'b1;
      req_sync <= 1'b1;
    end
    else
    begin
      req_meta <= req_pin; // [R19]
      req_sync <= req_meta; // [R19]
    end
  end

  // a high that ends early sends the low count back to one, so noise
  // can never add up to a trigger across several short pulses
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      low_cnt <= 8'h00;
      high_cnt <= 8'h00;
      armed <= 1'b0;
      trigger <= 1'b0;
    end
    else
    begin
      trigger <= 1'b0;
      if (!req_sync)
      begin
        high_cnt <= 8'h00;
        if (high_cnt != 8'h00)
        begin
          armed <= 1'b0; // [R1]
          low_cnt <= 8'h01;
        end
        else if (low_cnt == QUAL[7:0] - 8'h01)
          armed <= 1'b1; // [R1]
        else
          low_cnt <= low_cnt + 8'h01;
      end
      else
      begin
        low_cnt <= 8'h00;
        if (armed)
        begin
          if (high_cnt == QUAL[7:0] - 8'h01)
          begin
            trigger <= 1'b1; // [R1] [R2]
            armed <= 1'b0;
            high_cnt <= 8'h00;
          end
          else
            high_cnt <= high_cnt + 8'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- rtl/cycle_timer.v
// Purpose: loadable down counter with a pause input
// Assumes: load_value of zero behaves as one
// Notes: done is a one-cycle pulse when the count runs out
`timescale 1ns/100ps
`default_nettype none

module cycle_timer #(
  parameter W = 24
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // control
  input wire load,
  input wire [W-1:0] load_value,
  input wire run,
  // status
  output reg busy,
  output reg done
);

  reg [W-1:0] cnt;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt <= {W{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (load)
      begin
        cnt <= load_value;
        busy <= 1'b1;
      end
      else if (run && busy)
      begin
        if (cnt <= {{(W-1){1'b0}}, 1'b1})
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
          cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule
`default_nettype wire

//--- rtl/calibration_sequencer.v
// Purpose: self-trim sequencing, output tri-state and range flag of a dual converter
// Assumes: aclk is the converter sample clock; registers over AXI4-Lite
// Notes: trim length is software-set; delays are parameters
//
// Function
// R1: trim request needs 80 low cycles then 80 high cycles; shorter ignored.
// R2: trim starts 80 cycles after the qualified rising of the request.
// R3: request high at power-up skips power-on trim until qualified sequence.
// R4: trim_in_progress is high for the whole trim and low otherwise.
// R5: data and output clock are tri-stated while trim runs.
// R6: outputs re-enable after trim; receiver waits about 100ns to settle.
// R7: controller watches trim_in_progress instead of assuming a duration.
// R8: trim runs at power-up and on command; same whether clock early or late.
// R9: power-on trim waits a delay picked by trim_delay_select.
// R10: power-up delay counter halts while full_power_down is high.
// R11: extended control mode forces the short power-up delay.
// R12: analog stays powered down while the sample clock is absent at power-up.
// R13: controller leaves dual-edge mode before requesting a trim.
// R14: controller should trim 20 s after power-up and on temperature change.
// R15: range flag high (negative leg low) while either bus result clips.
// R16: controller must not pulse data_clock_sync_reset during a trim.
// R17: power-down raised during trim takes effect when trim completes.
// R18: trim requests are ignored entirely while powered down.
// R19: request pin is synchronised before its intervals are counted.
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "cal_seq_defines.vh"

module calibration_sequencer #(
  parameter [23:0] SHORT_DELAY = `DLY_SHORT_CYCLES,
  parameter [23:0] LONG_DELAY = `DLY_LONG_CYCLES
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // control pins
  input wire self_trim_request,
  input wire trim_delay_select,
  input wire full_power_down,
  input wire sample_clock_alive,
  // converter core results, same clock
  input wire signed [9:0] bus_a_result,
  input wire signed [9:0] bus_b_result,
  // outputs
  output reg trim_in_progress,
  output reg analog_power_down,
  output reg [7:0] bus_a_data,
  output reg [7:0] bus_b_data,
  output reg data_oe_n,
  output reg output_data_clock_oe_n,
  output reg range_overflow_p,
  output reg range_overflow_n,
  output reg irq
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [2:0] ST_STRAP = 3'h0;
  localparam [2:0] ST_DELAY = 3'h1;
  localparam [2:0] ST_IDLE = 3'h2;
  localparam [2:0] ST_TRIM = 3'h3;
  localparam [2:0] ST_PD = 3'h4;

  reg [2:0] state;
  reg [1:0] strap_cnt;
  reg pd_meta;
  reg pd_sync;
  reg dly_meta;
  reg dly_sync;
  reg alive_meta;
  reg alive_sync;
  reg [`CTRL_W-1:0] ctrl;
  reg [`IRQ_W-1:0] int_status;
  reg [`IRQ_W-1:0] int_mask;
  reg [15:0] trim_len;
  reg [2:0] settle_cnt;
  reg settled;
  reg [7:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;
  reg [`IRQ_W-1:0] next_int_status;
  reg [`IRQ_W-1:0] events;
  reg overflow_now;
  reg dly_load;
  reg trim_load;
  wire req_level;
  wire trigger;
  wire dly_busy;
  wire dly_done;
  wire trim_busy;
  wire trim_done;
  wire [23:0] dly_value;
  wire rd_int_status;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function is_mapped;
    input [7:0] addr;
    begin
      is_mapped = (addr == `REG_CTRL) || (addr == `REG_STATUS) ||
                  (addr == `REG_INT_STATUS) || (addr == `REG_INT_MASK) ||
                  (addr == `REG_TRIM_LEN);
    end
  endfunction

  function [7:0] clip8;
    input signed [9:0] code;
    begin
      if (code < 10'sd0)
        clip8 = 8'h00;
      else if (code > 10'sd255)
        clip8 = 8'hFF;
      else
        clip8 = code[7:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pd_meta <= 1'b0;
      pd_sync <= 1'b0;
      dly_meta <= 1'b0;
      dly_sync <= 1'b0;
      alive_meta <= 1'b0;
      alive_sync <= 1'b0;
    end
    else
    begin
      pd_meta <= full_power_down;
      pd_sync <= pd_meta;
      dly_meta <= trim_delay_select;
      dly_sync <= dly_meta;
      alive_meta <= sample_clock_alive;
      alive_sync <= alive_meta;
    end
  end

  request_qualifier #(
    .QUAL(`QUAL_CYCLES)
  ) u_qual (
    .aclk(aclk),
    .aresetn(aresetn),
    .req_pin(self_trim_request),
    .req_level(req_level),
    .trigger(trigger)
  );

  // extended mode has no delay choice
  assign dly_value = (ctrl[`CTRL_EXT_MODE] || !dly_sync) ? SHORT_DELAY : LONG_DELAY; // [R9] [R11]

  // the delay keeps counting with or without the sample clock flag,
  // so power-on trim lands at the same point either way
  cycle_timer #(
    .W(24)
  ) u_dly (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(dly_load),
    .load_value(dly_value),
    .run(!pd_sync), // [R10] [R8]
    .busy(dly_busy),
    .done(dly_done)
  );

  cycle_timer #(
    .W(16)
  ) u_trim (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(trim_load),
    .load_value(trim_len),
    .run(1'b1),
    .busy(trim_busy),
    .done(trim_done)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ST_STRAP;
      strap_cnt <= 2'h0;
      dly_load <= 1'b0;
      trim_load <= 1'b0;
    end
    else
    begin
      dly_load <= 1'b0;
      trim_load <= 1'b0;
      case (state)
        ST_STRAP:
        begin
          // wait for the synchroniser to hold a real pin level
          strap_cnt <= strap_cnt + 2'h1;
          if (strap_cnt == 2'h3)
          begin
            if (req_level)
              state <= ST_IDLE; // [R3]
            else
            begin
              dly_load <= 1'b1;
              state <= ST_DELAY; // [R8]
            end
          end
        end
        ST_DELAY:
        begin
          if (trigger && !pd_sync)
          begin
            trim_load <= 1'b1;
            state <= ST_TRIM;
          end
          else if (dly_done)
          begin
            trim_load <= 1'b1;
            state <= ST_TRIM; // [R9]
          end
        end
        ST_IDLE:
        begin
          if (pd_sync)
            state <= ST_PD;
          else if (trigger)
          begin
            trim_load <= 1'b1;
            state <= ST_TRIM; // [R2]
          end
        end
        ST_TRIM:
        begin
          // power-down waits for the trim to finish
          if (trim_done)
            state <= pd_sync ? ST_PD : ST_IDLE; // [R17]
        end
        ST_PD:
        begin
          if (!pd_sync)
            state <= ST_IDLE; // [R18]
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trim_in_progress <= 1'b0;
      analog_power_down <= 1'b1;
      data_oe_n <= 1'b1;
      output_data_clock_oe_n <= 1'b1;
      bus_a_data <= 8'h00;
      bus_b_data <= 8'h00;
      range_overflow_p <= 1'b0;
      range_overflow_n <= 1'b1;
      settle_cnt <= 3'h0;
      settled <= 1'b0;
    end
    else
    begin
      trim_in_progress <= (state == ST_TRIM) && !trim_done; // [R4]
      analog_power_down <= (state == ST_PD) ||
                           ((state == ST_DELAY || state == ST_STRAP) && !alive_sync); // [R12]
      // outputs tri-state during trim and power-down, back on once trim ends
      data_oe_n <= (state == ST_TRIM && !trim_done) || state == ST_PD; // [R5] [R6]
      output_data_clock_oe_n <= (state == ST_TRIM && !trim_done) || state == ST_PD; // [R5] [R6]
      bus_a_data <= clip8(bus_a_result);
      bus_b_data <= clip8(bus_b_result);
      range_overflow_p <= overflow_now; // [R15]
      range_overflow_n <= !overflow_now; // [R15]
      if (!data_oe_n)
      begin
        if (settle_cnt != `SETTLE_CYCLES)
          settle_cnt <= settle_cnt + 3'h1; // [R6]
        settled <= (settle_cnt == `SETTLE_CYCLES);
      end
      else
      begin
        settle_cnt <= 3'h0;
        settled <= 1'b0;
      end
    end
  end

  always @*
  begin
    overflow_now = (bus_a_result < 10'sd0) || (bus_a_result > 10'sd255) ||
                   (bus_b_result < 10'sd0) || (bus_b_result > 10'sd255); // [R15]
    events = {`IRQ_W{1'b0}};
    events[`IRQ_TRIM_START] = trim_load;
    events[`IRQ_TRIM_DONE] = trim_done;
    events[`IRQ_OVERFLOW] = overflow_now && !range_overflow_p;
    events[`IRQ_REQ_IGNORED] = trigger && (state == ST_PD || state == ST_TRIM ||
                                           (state != ST_IDLE && pd_sync)); // [R18]
    // a new event beats the clear-on-read in the same cycle
    next_int_status = (rd_int_status ? {`IRQ_W{1'b0}} : int_status) | events;
  end

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  assign rd_int_status = s_axi_arvalid && s_axi_arready && (s_axi_araddr == `REG_INT_STATUS);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
      aw_addr <= 8'h00;
      aw_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      w_held <= 1'b0;
      ctrl <= `CTRL_RESET;
      int_mask <= `INT_MASK_RESET;
      trim_len <= `TRIM_LEN_RESET;
      int_status <= {`IRQ_W{1'b0}};
      irq <= 1'b0;
    end
    else
    begin
      int_status <= next_int_status;
      irq <= |(int_status & int_mask);
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_held && w_held && !s_axi_bvalid)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_addr) ? 2'h0 : 2'h2;
        if (aw_addr == `REG_CTRL)
          ctrl <= w_strb[0] ? w_data[`CTRL_W-1:0] : ctrl;
        if (aw_addr == `REG_INT_MASK)
          int_mask <= w_strb[0] ? w_data[`IRQ_W-1:0] : int_mask;
        if (aw_addr == `REG_TRIM_LEN)
          trim_len <= {w_strb[1] ? w_data[15:8] : trim_len[15:8],
                       w_strb[0] ? w_data[7:0] : trim_len[7:0]};
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !s_axi_arvalid ? 1'b1 :
                       (!s_axi_rvalid && !s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= is_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
        case (s_axi_araddr)
          `REG_CTRL: s_axi_rdata <= {30'h0, ctrl};
          `REG_STATUS: s_axi_rdata <= {27'h0, analog_power_down, settled,
                                       range_overflow_p, state == ST_PD, trim_in_progress};
          `REG_INT_STATUS: s_axi_rdata <= {28'h0, int_status};
          `REG_INT_MASK: s_axi_rdata <= {28'h0, int_mask};
          `REG_TRIM_LEN: s_axi_rdata <= {16'h0, trim_len};
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- test/cal_seq_properties.sv
// Purpose: port checker of the calibration sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: trim length kept at 8 cycles or more by the bench
`timescale 1ns/100ps
`default_nettype none
module cal_seq_properties (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins and core results
  input wire logic self_trim_request,
  input wire logic full_power_down,
  input wire logic signed [9:0] bus_a_result,
  input wire logic signed [9:0] bus_b_result,
  // outputs
  input wire logic trim_in_progress,
  input wire logic analog_power_down,
  input wire logic [7:0] bus_a_data,
  input wire logic data_oe_n,
  input wire logic output_data_clock_oe_n,
  input wire logic range_overflow_p,
  input wire logic range_overflow_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [7:0] hi_cnt;
  logic [3:0] pd_cnt;
  wire clip = bus_a_result < 0 || bus_a_result > 255 || bus_b_result < 0 || bus_b_result > 255;
  // ----
  // run-length counters of the raw pins
  // ----
  always @(posedge aclk)
  begin
    if (!aresetn || !self_trim_request)
      hi_cnt <= 8'h00;
    else if (hi_cnt != 8'hFF)
      hi_cnt <= hi_cnt + 8'h01;
    if (!aresetn || !full_power_down)
      pd_cnt <= 4'h0;
    else if (pd_cnt != 4'hF)
      pd_cnt <= pd_cnt + 4'h1;
  end
  sequence pd_quiet;
    (!full_power_down)[*4];
  endsequence
  sequence trim_end;
    pd_quiet ##0 $fell(trim_in_progress);
  endsequence
  AST_OE_IN_TRIM: assert property (trim_in_progress |-> data_oe_n && output_data_clock_oe_n)
    else $error("outputs driven during trim");
  AST_TRIM_QUAL: assert property ($rose(trim_in_progress) && self_trim_request |-> hi_cnt >= 8'h50)
    else $error("trim started by a short high interval");
  AST_PD_NO_START: assert property ($rose(trim_in_progress) |-> pd_cnt < 4'h8)
    else $error("trim started while powered down");
  AST_ANALOG_ON: assert property (trim_in_progress |-> !analog_power_down)
    else $error("analog off during trim");
  AST_TRIM_MIN: assert property ($rose(trim_in_progress) |-> trim_in_progress[*8])
    else $error("trim indicator dropped early");
  AST_OE_BACK: assert property (trim_end |-> !data_oe_n && !output_data_clock_oe_n)
    else $error("outputs not enabled after trim");
  AST_OVF_SET: assert property (clip |=> range_overflow_p && !range_overflow_n)
    else $error("range flag missing");
  AST_OVF_CLR: assert property (!clip |=> !range_overflow_p && range_overflow_n)
    else $error("range flag without clipping");
  AST_CLIP_HI: assert property (bus_a_result > 255 |=> bus_a_data == 8'hFF)
    else $error("high result not clipped");
endmodule
bind calibration_sequencer cal_seq_properties chk (.*);
`default_nettype wire

//--- test/trim_controller.sv
// Purpose: external controller driving the trim request pin
// Assumes: called just after a rising edge
// Notes: completion is taken from the indicator only
`timescale 1ns/100ps
`default_nettype none
module trim_controller (
  // clock
  input wire logic aclk,
  // device status
  input wire logic trim_in_progress,
  // request pin
  output logic self_trim_request
);
  initial self_trim_request = 1'h1;
  // only the request pin is driven, never the clock sync reset
  task pulse(input int lo, input int hi);
    begin
      self_trim_request <= 1'h0;
      repeat (lo) @(posedge aclk);
      self_trim_request <= 1'h1;
      repeat (hi) @(posedge aclk);
    end
  endtask
  // trim length is software-set, so no fixed wait is assumed
  task wait_lvl(input logic lvl, input int lim, output int n);
    begin
      n = 0;
      while (trim_in_progress !== lvl && n < lim)
      begin
        @(posedge aclk);
        n++;
      end
    end
  endtask
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Purpose: self-checking bench of the calibration sequencer
// Assumes: delays shortened to 16 and 200 cycles
// Notes: bready and rready stay high, which the bus allows
`timescale 1ns/100ps
`default_nettype none
`include "cal_seq_defines.vh"
module tb_top;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, bus_a_data, bus_b_data;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic trim_delay_select = 1'h0, full_power_down = 1'h0, sample_clock_alive = 1'h1;
  logic signed [9:0] bus_a_result = 10'h064, bus_b_result = 10'h064;
  logic trim_in_progress, analog_power_down, data_oe_n, output_data_clock_oe_n;
  logic range_overflow_p, range_overflow_n, irq;
  wire self_trim_request;
  int num_errors = 0, samples_checked = 0;
  always #12.5 aclk = ~aclk;
  calibration_sequencer #(.SHORT_DELAY(24'h000010), .LONG_DELAY(24'h0000C8)) DUT (.*);
  trim_controller ctl (.*);
  // ----
  // shared tasks
  // ----
  task check(input string nm, input logic [31:0] seen, exp);
    begin
      samples_checked++;
      if (seen !== exp)
      begin
        num_errors++;
        $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do
      begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready)
          s_axi_awvalid <= 1'h0;
        if (s_axi_wvalid && s_axi_wready)
          s_axi_wvalid <= 1'h0;
        r = s_axi_bresp;
      end
      while (!s_axi_bvalid);
    end
  endtask
  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do
      begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready)
          s_axi_arvalid <= 1'h0;
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
      while (!s_axi_rvalid);
    end
  endtask
  task do_reset(input logic sel, pd, pin, alive);
    begin
      aresetn <= 1'h0;
      trim_delay_select <= sel;
      full_power_down <= pd;
      sample_clock_alive <= alive;
      ctl.self_trim_request <= pin;
      step(16);
      aresetn <= 1'h1;
    end
  endtask
  // ----
  // scenarios
  // ----
  task t_powerup(input logic sel, pd, alive, input int lo, hi);
    int n;
    logic [1:0] r;
    begin
      do_reset(sel, pd, 1'h0, alive);
      if (pd)
      begin
        axi_wr(`REG_CTRL, 32'h1, r);
        step(300);
        check("held start", trim_in_progress, 32'h0);
        full_power_down <= 1'h0;
      end
      if (!alive)
      begin
        step(20);
        check("analog off", analog_power_down, 32'h1);
        sample_clock_alive <= 1'h1;
      end
      ctl.wait_lvl(1'h1, 400, n);
      check("start early", n >= lo, 32'h1);
      check("start late", n < hi, 32'h1);
      ctl.wait_lvl(1'h0, 1100, n);
      check("trim len", n >= 1023 && n <= 1026, 32'h1);
    end
  endtask
  task t_regs;
    logic [31:0] d;
    logic [1:0] r;
    begin
      axi_rd(`REG_CTRL, d, r);
      check("ctrl", d, 32'h0);
      axi_rd(`REG_INT_MASK, d, r);
      check("mask", d, 32'h0);
      axi_rd(`REG_TRIM_LEN, d, r);
      check("len reg", d, 32'h400);
      axi_rd(8'h20, d, r);
      check("rd resp", r, 32'h2);
      check("rd data", d, 32'h0);
      axi_wr(8'h20, 32'h1, r);
      check("wr resp", r, 32'h2);
    end
  endtask
  task t_skip;
    int n;
    begin
      do_reset(1'h0, 1'h0, 1'h1, 1'h1);
      step(300);
      check("no power-on trim", trim_in_progress, 32'h0);
      ctl.pulse(90, 0);
      ctl.wait_lvl(1'h1, 150, n);
      check("late trim", n >= 80 && n <= 90, 32'h1);
      ctl.wait_lvl(1'h0, 1100, n);
    end
  endtask
  task t_cmd;
    int n;
    logic [31:0] d;
    logic [1:0] r;
    begin
      axi_wr(`REG_CTRL, 32'h0, r);
      axi_wr(`REG_TRIM_LEN, 32'h20, r);
      axi_wr(`REG_INT_MASK, 32'hF, r);
      axi_rd(`REG_INT_STATUS, d, r);
      ctl.pulse(90, 0);
      ctl.wait_lvl(1'h1, 150, n);
      check("cmd start", n >= 80 && n <= 90, 32'h1);
      check("oe off", {data_oe_n, output_data_clock_oe_n}, 32'h3);
      ctl.wait_lvl(1'h0, 100, n);
      check("cmd len", n >= 32 && n <= 34, 32'h1);
      check("oe on", {data_oe_n, output_data_clock_oe_n}, 32'h0);
      step(6);
      axi_rd(`REG_STATUS, d, r);
      check("settled", d[3], 32'h1);
      check("irq", irq, 32'h1);
      axi_rd(`REG_INT_STATUS, d, r);
      check("events", d, 32'h3);
      step(2);
      check("irq clear", irq, 32'h0);
    end
  endtask
  task t_short;
    logic [31:0] d;
    logic [1:0] r;
    begin
      axi_rd(`REG_INT_STATUS, d, r);
      ctl.pulse(90, 60);
      ctl.pulse(50, 150);
      axi_rd(`REG_INT_STATUS, d, r);
      check("short pulses", d, 32'h0);
    end
  endtask
  task t_pd;
    int n;
    logic [31:0] d;
    logic [1:0] r;
    begin
      axi_wr(`REG_INT_MASK, 32'h0, r);
      full_power_down <= 1'h1;
      step(10);
      check("pd outputs", {data_oe_n, analog_power_down}, 32'h3);
      ctl.pulse(90, 150);
      check("masked irq", irq, 32'h0);
      axi_rd(`REG_INT_STATUS, d, r);
      check("ignored", d, 32'h8);
      full_power_down <= 1'h0;
      step(10);
      ctl.pulse(90, 0);
      ctl.wait_lvl(1'h1, 150, n);
      full_power_down <= 1'h1;
      ctl.wait_lvl(1'h0, 100, n);
      check("trim kept", n >= 30 && n <= 34, 32'h1);
      step(4);
      check("pd after", analog_power_down, 32'h1);
      full_power_down <= 1'h0;
      step(10);
    end
  endtask
  task t_range;
    logic [9:0] a [4] = '{10'h3FF, 10'h000, 10'h0FF, 10'h1FF};
    logic [9:0] b [4] = '{10'h064, 10'h064, 10'h064, 10'h100};
    logic [7:0] q [4] = '{8'h00, 8'h00, 8'hFF, 8'hFF};
    begin
      for (int i = 0; i < 4; i++)
      begin
        bus_a_result <= a[i];
        bus_b_result <= b[i];
        step(3);
        check("flag", {range_overflow_p, range_overflow_n}, (i % 3) ? 32'h1 : 32'h2);
        check("data", bus_a_data, q[i]);
        check("data b", bus_b_data, i == 3 ? 32'hFF : 32'h64);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial
  begin
    #(30000 * 25);
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    t_powerup(1'h0, 1'h0, 1'h1, 16, 40);
    t_regs();
    t_powerup(1'h1, 1'h0, 1'h0, 170, 230);
    t_powerup(1'h1, 1'h1, 1'h1, 16, 40);
    t_skip();
    t_cmd();
    t_short();
    t_pd();
    t_range();
    report_and_stop();
  end
endmodule
`default_nettype wire
